// ### host_model.sv
/* host side of the register group: byte reads and writes.
   assumes rdata answers one cycle after acc is presented. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                       clk,
    input  wire logic [7:0]                 rdata,
    output var result_cal_pkg::reg_access_t acc,
    output logic                            read_busy
);
    // ==========================================================
    // byte cycles, all driven 1 ns after the edge
    initial begin
        acc = '0;
        read_busy = 1'b0;
    end
    task automatic wb(input logic [1:0] s, input logic [1:0] i, input logic [7:0] d);
        @(posedge clk) #1 acc = {s, i, 1'b1, d};
        @(posedge clk) #1 acc.wr = 1'b0;
    endtask
    task automatic rb(input logic [1:0] s, input logic [1:0] i, output logic [7:0] d);
        @(posedge clk) #1 acc = {s, i, 1'b0, 8'h00};
        @(posedge clk) #1 d = rdata;
    endtask
    task automatic busy(input logic b);
        @(posedge clk) #1 read_busy = b;
    endtask
endmodule
`default_nettype wire

// ### result_cal_pkg.sv
/*
 * shared constants and carrier types for the result and calibration
 * register group. assumes a serial front end that decodes byte
 * accesses and a filter that delivers raw 24-bit conversion values.
 */
package result_cal_pkg;
    // ==========================================================
    // register map (byte index within a 24-bit register)
    localparam int unsigned WORD_W        = 24;
    localparam logic [1:0]  SEL_RESULT    = 2'h0;
    localparam logic [1:0]  SEL_OFFSET    = 2'h1;
    localparam logic [1:0]  SEL_FULLSCALE = 2'h2;
    localparam logic [1:0]  BYTE_HI       = 2'h2;
    localparam logic [1:0]  BYTE_MID      = 2'h1;
    localparam logic [1:0]  BYTE_LO       = 2'h0;
    // ==========================================================
    // reset values and correction function
    localparam logic [23:0] RESULT_RST    = 24'h000000;
    localparam logic [23:0] OFFSET_RST    = 24'h000000;
    // unity gain at mid code of the unsigned full-scale word
    localparam logic [23:0] FULLSCALE_RST = 24'h800000;
    localparam int unsigned GAIN_SHIFT    = 23;
    localparam int unsigned OFFSET_SCALE  = 1;
    // ==========================================================
    // timing
    localparam int unsigned GUARD_MCLK    = 12;

    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] byte_idx;
        logic       wr;
        logic [7:0] wdata;
    } reg_access_t;

    typedef struct packed {
        logic [23:0] result;
        logic [23:0] offset;
        logic [23:0] fullscale;
        logic        avail_n;
        logic        pending;
        logic [23:0] pend_val;
        logic [7:0]  rdata;
    } state_t;
endpackage

// ### result_cal_regs.sv
/*
 * conversion result, offset and full-scale correction registers.
 * assumes conv_valid pulses once per conversion with a raw value,
 * and that the serial front end marks a result read with read_busy.
 */
`timescale 1ns/1ps
`default_nettype none

module result_cal_regs (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         conv_valid,
    input  wire logic [23:0]                  conv_raw,
    input  wire logic                         cal_offset_load,
    input  wire logic                         cal_fullscale_load,
    input  wire logic [23:0]                  cal_value,
    input  wire logic                         result_coding_select,
    input  wire logic                         unipolar_select,
    input  wire logic                         read_busy,
    input  wire result_cal_pkg::reg_access_t  acc,
    output logic [7:0]                        rdata,
    output logic                              result_available_n,
    output logic [23:0]                       full_scale_correction_bits
);
    // ==========================================================
    // state
    result_cal_pkg::state_t st_r;
    result_cal_pkg::state_t st_nxt;

    logic signed [24:0] off_applied;
    logic signed [25:0] shifted;
    logic signed [50:0] product;
    logic signed [50:0] scaled;
    logic signed [23:0] corrected;
    logic [23:0]        coded;

    // ==========================================================
    // correction path
    always_comb begin
        off_applied = 25'(signed'(st_r.offset)) * 25'(result_cal_pkg::OFFSET_SCALE);
        shifted = 26'(signed'(conv_raw)) - 26'(off_applied);
        product = 51'(shifted) * 51'(signed'({1'b0, st_r.fullscale}));
        scaled = product >>> result_cal_pkg::GAIN_SHIFT;
        // saturate to the signed 24-bit range
        if (scaled > 51'sh7fffff) begin
            corrected = 24'sh7fffff;
        end else if (scaled < -51'sh800000) begin
            corrected = 24'sh800000;
        end else begin
            corrected = scaled[23:0];
        end
        if (unipolar_select && corrected[23]) begin
            corrected = 24'sh000000;
        end
        // coding select, high means two's complement
        coded = result_coding_select ? corrected : {~corrected[23], corrected[22:0]};
    end

    // ==========================================================
    // register update
    always_comb begin
        st_nxt = st_r;
        // force data-ready high before a load
        if (conv_valid && !read_busy) begin
            st_nxt.avail_n = 1'b1;
            st_nxt.pending = 1'b1;
            st_nxt.pend_val = coded;
        end else if (conv_valid) begin
            // read in progress: hold data-ready, load after the read
            st_nxt.pending = 1'b1;
            st_nxt.pend_val = coded;
        end else if (st_r.pending && !read_busy && st_r.avail_n) begin
            st_nxt.result = st_r.pend_val;
            st_nxt.avail_n = 1'b0;
            st_nxt.pending = 1'b0;
        end else if (st_r.pending && !read_busy) begin
            st_nxt.avail_n = 1'b1;
        end
        if (acc.wr && acc.byte_idx <= result_cal_pkg::BYTE_HI) begin
            if (acc.sel == result_cal_pkg::SEL_OFFSET) begin
                st_nxt.offset[acc.byte_idx*8 +: 8] = acc.wdata;
            end else if (acc.sel == result_cal_pkg::SEL_FULLSCALE) begin
                st_nxt.fullscale[acc.byte_idx*8 +: 8] = acc.wdata;
            end
        end
        // calibration loads
        // applied after host writes so a calibration wins a same-cycle clash
        if (cal_offset_load) begin
            st_nxt.offset = cal_value;
        end
        if (cal_fullscale_load) begin
            st_nxt.fullscale = cal_value;
        end
        // byte read mux
        // byte 3 lies outside the word and reads as zero
        if (acc.byte_idx > result_cal_pkg::BYTE_HI) begin
            st_nxt.rdata = 8'h00;
        end else if (acc.sel == result_cal_pkg::SEL_RESULT) begin
            st_nxt.rdata = st_r.result[acc.byte_idx*8 +: 8];
        end else if (acc.sel == result_cal_pkg::SEL_OFFSET) begin
            st_nxt.rdata = st_r.offset[acc.byte_idx*8 +: 8];
        end else if (acc.sel == result_cal_pkg::SEL_FULLSCALE) begin
            st_nxt.rdata = st_r.fullscale[acc.byte_idx*8 +: 8];
        end else begin
            st_nxt.rdata = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r.result    <= result_cal_pkg::RESULT_RST;
            st_r.offset    <= result_cal_pkg::OFFSET_RST;
            st_r.fullscale <= result_cal_pkg::FULLSCALE_RST;
            st_r.avail_n   <= 1'b1;
            st_r.pending   <= 1'b0;
            st_r.pend_val  <= 24'h000000;
            st_r.rdata     <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign result_available_n = st_r.avail_n;
    assign full_scale_correction_bits = st_r.fullscale;

    // ==========================================================
    // checks
    // ready after load
    a_ready_after_load: assert property (@(posedge clk) disable iff (!nrst)
        $fell(st_r.avail_n) |-> st_r.result == $past(st_r.pend_val))
        else $error("data-ready fell without the pending value loaded");

    // conversion taken, then high, then loaded
    sequence conv_taken;
        conv_valid && !read_busy ##1 !read_busy && !conv_valid;
    endsequence
    sequence high_then_low;
        st_r.avail_n ##1 !st_r.avail_n;
    endsequence
    a_high_before_load: assert property (@(posedge clk) disable iff (!nrst)
        conv_taken |-> high_then_low)
        else $error("data-ready was not high before a load");

    // deferred drop once the read ends
    sequence read_ended_pending;
        $fell(read_busy) && st_r.pending && !st_r.avail_n ##1 !read_busy && !conv_valid;
    endsequence
    a_deferred_load: assert property (@(posedge clk) disable iff (!nrst)
        read_ended_pending |-> high_then_low)
        else $error("deferred load did not raise then drop data-ready");

    a_read_holds_ready: assert property (@(posedge clk) disable iff (!nrst)
        read_busy && !st_r.avail_n |=> !st_r.avail_n)
        else $error("data-ready changed during a read");

    // result changes only on a load
    a_result_on_load: assert property (@(posedge clk) disable iff (!nrst)
        !$stable(st_r.result) |-> $fell(st_r.avail_n))
        else $error("result changed without data-ready falling");

    a_offset_write: assert property (@(posedge clk) disable iff (!nrst)
        acc.wr && acc.sel == result_cal_pkg::SEL_OFFSET && acc.byte_idx == 2'h2
        && !cal_offset_load |=> st_r.offset[23:16] == $past(acc.wdata))
        else $error("offset high byte not written");

    a_fullscale_write: assert property (@(posedge clk) disable iff (!nrst)
        acc.wr && acc.sel == result_cal_pkg::SEL_FULLSCALE && acc.byte_idx == 2'h0
        && !cal_fullscale_load |=> st_r.fullscale[7:0] == $past(acc.wdata))
        else $error("full-scale low byte not written");

    a_cal_load: assert property (@(posedge clk) disable iff (!nrst)
        cal_offset_load |=> st_r.offset == $past(cal_value))
        else $error("calibration did not load offset");

    a_read_order: assert property (@(posedge clk) disable iff (!nrst)
        acc.sel == result_cal_pkg::SEL_RESULT && acc.byte_idx == 2'h2
        && $stable(st_r.result) ##1 $stable(st_r.result)
        |-> rdata == st_r.result[23:16])
        else $error("result high byte not on read data");

    a_unipolar_offset_binary: assert property (@(posedge clk) disable iff (!nrst)
        conv_valid && unipolar_select && !result_coding_select |-> coded[23])
        else $error("unipolar offset-binary result below zero");

    a_unipolar_twos_comp: assert property (@(posedge clk) disable iff (!nrst)
        conv_valid && unipolar_select && result_coding_select |-> !coded[23])
        else $error("unipolar two's complement result below zero");

    a_spare_byte_zero: assert property (@(posedge clk) disable iff (!nrst)
        acc.byte_idx == 2'h3 |=> rdata == 8'h00)
        else $error("out-of-range byte did not read as zero");

    a_result_read_only: assert property (@(posedge clk) disable iff (!nrst)
        acc.wr && acc.sel == result_cal_pkg::SEL_RESULT && !st_r.pending
        |=> $stable(st_r.result))
        else $error("host write reached the result register");
endmodule

`default_nettype wire

// ### result_cal_regs_test.sv
/* self-checking bench for the result and calibration registers.
   assumes the host model owns acc and read_busy. */
`timescale 1ns/1ps
`default_nettype none
module result_cal_regs_test;
    logic clk, nrst, conv_valid, cal_offset_load, cal_fullscale_load;
    logic coding, uni, read_busy, avail_n;
    logic [23:0] conv_raw, cal_value, fsb, v;
    logic [7:0] rdata, d;
    result_cal_pkg::reg_access_t acc;
    int n_fail, total_checks;

    result_cal_regs dut (.clk(clk), .nrst(nrst), .conv_valid(conv_valid),
        .conv_raw(conv_raw), .cal_offset_load(cal_offset_load),
        .cal_fullscale_load(cal_fullscale_load), .cal_value(cal_value),
        .result_coding_select(coding), .unipolar_select(uni), .read_busy(read_busy),
        .acc(acc), .rdata(rdata), .result_available_n(avail_n),
        .full_scale_correction_bits(fsb));
    host_model host (.clk(clk), .rdata(rdata), .acc(acc), .read_busy(read_busy));

    always #4 clk = ~clk;
    // ==========================================================
    // helpers
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [1:0] s, input logic [23:0] x);
        for (int b = 2; b >= 0; b--) host.wb(s, b[1:0], x[b*8+:8]);
    endtask
    task automatic rd(input logic [1:0] s, output logic [23:0] x);
        logic [7:0] t;
        for (int b = 2; b >= 0; b--) begin
            host.rb(s, b[1:0], t);
            x[b*8+:8] = t;
        end
    endtask
    // high first, then low within four cycles, also after a deferred load
    task automatic ready_wait();
        logic hi;
        hi = 1'b0;
        for (int k = 0; k < 4 && !(hi && avail_n === 1'b0); k++) begin
            hi |= (avail_n === 1'b1);
            @(posedge clk) #1;
        end
        chk({22'h0, hi, avail_n}, 24'h2);
    endtask
    task automatic conv(input logic [23:0] raw, input logic w);
        @(posedge clk) #1 conv_valid = 1'b1;
        conv_raw = raw;
        @(posedge clk) #1 conv_valid = 1'b0;
        conv_raw = ~raw;
        if (w) ready_wait();
    endtask
    task automatic calp(input logic f, input logic [23:0] x);
        @(posedge clk) #1 cal_value = x;
        cal_offset_load = !f;
        cal_fullscale_load = f;
        @(posedge clk) #1 cal_offset_load = 1'b0;
        cal_fullscale_load = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        {clk, nrst, conv_valid, cal_offset_load, cal_fullscale_load, uni} = '0;
        {conv_raw, cal_value, n_fail, total_checks} = '0;
        coding = 1'b1;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        chk(fsb, result_cal_pkg::FULLSCALE_RST);
        rd(result_cal_pkg::SEL_OFFSET, v);
        chk(v, result_cal_pkg::OFFSET_RST);
        wr(result_cal_pkg::SEL_OFFSET, 24'h000010);
        wr(result_cal_pkg::SEL_FULLSCALE, 24'hc00000);
        rd(result_cal_pkg::SEL_OFFSET, v);
        chk(v, 24'h000010);
        rd(result_cal_pkg::SEL_FULLSCALE, v);
        chk(v, 24'hc00000);
        chk(fsb, 24'hc00000);
        // gain 1.5 of (raw - offset)
        conv(24'h000110, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h000180);
        coding = 1'b0;
        conv(24'h000110, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h800180);
        coding = 1'b1;
        uni = 1'b1;
        conv(24'hffff00, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h000000);
        coding = 1'b0;
        conv(24'hffff00, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h800000);
        coding = 1'b1;
        uni = 1'b0;
        conv(24'hffff00, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'hfffe68);
        // two conversions land during a read
        host.busy(1'b1);
        conv(24'h000210, 1'b0);
        repeat (2) @(posedge clk);
        conv(24'h000310, 1'b0);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'hfffe68);
        chk({23'h0, avail_n}, 24'h0);
        host.busy(1'b0);
        ready_wait();
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h000480);
        wr(result_cal_pkg::SEL_RESULT, 24'h123456);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h000480);
        host.rb(result_cal_pkg::SEL_OFFSET, 2'h3, d);
        chk({16'h0, d}, 24'h0);
        // calibration load beats a host write in the same cycle
        fork
            host.wb(result_cal_pkg::SEL_OFFSET, result_cal_pkg::BYTE_LO, 8'h55);
            calp(1'b0, 24'h000020);
        join
        calp(1'b1, 24'h800000);
        rd(result_cal_pkg::SEL_OFFSET, v);
        chk(v, 24'h000020);
        chk(fsb, 24'h800000);
        conv(24'h000120, 1'b1);
        rd(result_cal_pkg::SEL_RESULT, v);
        chk(v, 24'h000100);
        tally_and_finish();
    end
    // whole run needs well under 1000 cycles
    initial begin
        #(8 * 4000);
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
